// file: rtl/muxed_bus_interface.v
// Purpose: multiplexed address/data bus sequencer with two I/O ports
// Assumes: sys_clk_in is the oscillator input; bus cycle = five clocks
// Notes: a software command port over AXI4-Lite stands in for the CPU core
`include "muxed_bus_regs.vh"

module muxed_bus_interface (
	input  wire        sys_clk_in,
	input  wire        reset_n_in,
	input  wire [7:0]  s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output reg         s_axi_awready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output reg         s_axi_wready_out,
	output reg  [1:0]  s_axi_bresp_out,
	output reg         s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	input  wire [7:0]  s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output reg         s_axi_arready_out,
	output reg  [31:0] s_axi_rdata_out,
	output reg  [1:0]  s_axi_rresp_out,
	output reg         s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	input  wire        irq_n_in,
	output reg         address_strobe_out,
	output reg         data_strobe_out,
	output reg         read_write_n_out,
	output reg  [4:0]  upper_address_lines_out,
	input  wire [7:0]  muxed_addr_data_lines_in,
	output reg  [7:0]  muxed_addr_data_lines_out,
	output reg         muxed_addr_data_lines_oe_out,
	output reg         opcode_fetch_flag_out,
	input  wire [7:0]  port_a_pins_in,
	output reg  [7:0]  port_a_pins_out,
	output reg  [7:0]  port_a_pins_oe_out,
	input  wire [7:0]  port_b_pins_in,
	output reg  [7:0]  port_b_pins_out,
	output reg  [7:0]  port_b_pins_oe_out,
	output reg         irq_pending_out
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// internal page test
	function is_internal;
		input [12:0] a;
		begin
			is_internal = (a <= `INTERNAL_TOP) &&
				!(a[6:0] >= `ADR_EXT_LO_FIRST && a[6:0] <= `ADR_EXT_LO_LAST);
		end
	endfunction

	reg  [2:0]  phase_reg;
	reg         cyc_active_reg;
	reg         cyc_write_reg;
	reg         cyc_fetch_reg;
	reg  [12:0] cyc_addr_reg;
	reg  [7:0]  cyc_wdata_reg;
	reg  [12:0] addr_reg;
	reg  [7:0]  wdata_reg;
	reg  [7:0]  rdata_reg;
	reg         write_sel_reg;
	reg         fetch_sel_reg;
	reg         go_reg;
	reg         busy_reg;
	reg         done_reg;
	reg         wait_reg;
	reg         stop_reg;
	reg         imask_reg;
	reg         irq_latch_reg;
	reg         servicing_reg;
	reg         vector_hit_reg;
	reg  [5:0]  sp_reg;
	reg  [7:0]  latch_a_reg;
	reg  [7:0]  latch_b_reg;
	reg  [7:0]  dir_a_reg;
	reg  [7:0]  dir_b_reg;
	reg  [7:0]  ram_mem [0:127];
	reg  [7:0]  int_rdata;
	reg         aw_got_reg;
	reg         w_got_reg;
	reg  [7:0]  aw_addr_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg  [2:0]  phase_next;

	wire        idle_mode = wait_reg | stop_reg;
	wire        do_write  = aw_got_reg & w_got_reg & ~s_axi_bvalid_out;
	wire        ctrl_iack = do_write && aw_addr_reg == `REG_CTRL && w_data_reg[`CTRL_IACK];
	wire [12:0] sp_addr   = {`STACK_PAGE, sp_reg};

	// Internal read mux; per-bit latch or live pin
	always @* begin
		case (cyc_addr_reg[6:0])
			`ADR_PORTA_DATA: int_rdata = (latch_a_reg & dir_a_reg) | (port_a_pins_in & ~dir_a_reg);
			`ADR_PORTB_DATA: int_rdata = (latch_b_reg & dir_b_reg) | (port_b_pins_in & ~dir_b_reg);
			`ADR_PORTA_DIR:  int_rdata = dir_a_reg;
			`ADR_PORTB_DIR:  int_rdata = dir_b_reg;
			default:         int_rdata = ram_mem[cyc_addr_reg[6:0]];
		endcase
	end

	// ----------------------------------------
	// Bus phase counter
	// ----------------------------------------
	// divide by five
	always @* begin
		if (phase_reg == `OSC_DIV - 3'h1)
			phase_next = `PH_ADDR;
		else
			phase_next = phase_reg + 3'h1;
	end

	// ----------------------------------------
	// Bus sequencer and ports
	// ----------------------------------------
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			phase_reg                    <= 3'h0;
			cyc_active_reg               <= 1'b0;
			cyc_write_reg                <= 1'b0;
			cyc_fetch_reg                <= 1'b0;
			cyc_addr_reg                 <= 13'h0000;
			cyc_wdata_reg                <= 8'h00;
			rdata_reg                    <= 8'h00;
			busy_reg                     <= 1'b0;
			done_reg                     <= 1'b0;
			servicing_reg                <= 1'b0;
			vector_hit_reg               <= 1'b0;
			dir_a_reg                    <= 8'h00;
			dir_b_reg                    <= 8'h00;
			address_strobe_out           <= 1'b0;
			data_strobe_out              <= 1'b0;
			read_write_n_out             <= 1'b1;
			upper_address_lines_out      <= 5'h00;
			muxed_addr_data_lines_out    <= 8'h00;
			muxed_addr_data_lines_oe_out <= 1'b0;
			opcode_fetch_flag_out        <= 1'b0;
			port_a_pins_oe_out           <= 8'h00;
			port_b_pins_oe_out           <= 8'h00;
		end else begin
			port_a_pins_oe_out <= dir_a_reg;
			port_b_pins_oe_out <= dir_b_reg;
			if (go_reg)
				busy_reg <= 1'b1;
			if (go_reg)
				done_reg <= 1'b0;
			if (idle_mode) begin
				phase_reg                    <= 3'h0;
				address_strobe_out           <= 1'b0;
				data_strobe_out              <= 1'b0;
				read_write_n_out             <= 1'b1;
				muxed_addr_data_lines_oe_out <= 1'b0;
				opcode_fetch_flag_out        <= 1'b0;
			end else begin
				phase_reg <= phase_next;
				case (phase_reg)
					`PH_ADDR: begin
						// Idle slots run as redundant opcode reads
						cyc_active_reg <= busy_reg;
						cyc_write_reg  <= busy_reg & write_sel_reg;
						cyc_fetch_reg  <= ~busy_reg | fetch_sel_reg;
						cyc_addr_reg   <= addr_reg;
						cyc_wdata_reg  <= wdata_reg;
						upper_address_lines_out      <= addr_reg[12:8];
						muxed_addr_data_lines_out    <= addr_reg[7:0];
						muxed_addr_data_lines_oe_out <= 1'b1;
					end
					`PH_AS_HI: begin
						address_strobe_out <= 1'b1;
						read_write_n_out   <= ~cyc_write_reg;
					end
					`PH_AS_LO: begin
						address_strobe_out <= 1'b0;
					end
					`PH_DS_HI: begin
						data_strobe_out <= 1'b1;
						opcode_fetch_flag_out <= cyc_fetch_reg & ~servicing_reg;
						muxed_addr_data_lines_out    <= cyc_wdata_reg;
						muxed_addr_data_lines_oe_out <= cyc_write_reg;
						if (cyc_write_reg && is_internal(cyc_addr_reg)) begin
							case (cyc_addr_reg[6:0])
								`ADR_PORTA_DIR: dir_a_reg <= cyc_wdata_reg;
								`ADR_PORTB_DIR: dir_b_reg <= cyc_wdata_reg;
								default: ;
							endcase
						end
					end
					default: begin
						data_strobe_out              <= 1'b0;
						opcode_fetch_flag_out        <= 1'b0;
						read_write_n_out             <= 1'b1;
						muxed_addr_data_lines_oe_out <= 1'b0;
						if (cyc_active_reg) begin
							if (!cyc_write_reg)
								rdata_reg <= is_internal(cyc_addr_reg) ?
									int_rdata : muxed_addr_data_lines_in;
							vector_hit_reg <= (cyc_addr_reg >= `VECTOR_BASE);
							busy_reg       <= 1'b0;
							done_reg       <= 1'b1;
							cyc_active_reg <= 1'b0;
						end
					end
				endcase
			end
			if (ctrl_iack)
				servicing_reg <= irq_pending_out;
			else if (cyc_fetch_reg && cyc_active_reg && phase_reg == `PH_DS_LO)
				servicing_reg <= 1'b0;
		end
	end

	// Port output latches and RAM have no reset
	always @(posedge sys_clk_in) begin
		if (!idle_mode && phase_reg == `PH_DS_HI && cyc_write_reg &&
			is_internal(cyc_addr_reg)) begin
			case (cyc_addr_reg[6:0])
				`ADR_PORTA_DATA: latch_a_reg <= cyc_wdata_reg;
				`ADR_PORTB_DATA: latch_b_reg <= cyc_wdata_reg;
				default: ram_mem[cyc_addr_reg[6:0]] <= cyc_wdata_reg;
			endcase
		end
		port_a_pins_out <= latch_a_reg;
		port_b_pins_out <= latch_b_reg;
	end

	// ----------------------------------------
	// Interrupt input
	// ----------------------------------------
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_latch_reg   <= 1'b0;
			irq_pending_out <= 1'b0;
		end else begin
			// level or pulse latched; set wins
			if (!irq_n_in)
				irq_latch_reg <= 1'b1;
			else if (ctrl_iack)
				irq_latch_reg <= 1'b0;
			irq_pending_out <= (irq_latch_reg | ~irq_n_in) & ~imask_reg;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `AXI_RESP_OKAY;
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rresp_out   <= `AXI_RESP_OKAY;
			s_axi_rdata_out   <= 32'h00000000;
			aw_got_reg        <= 1'b0;
			w_got_reg         <= 1'b0;
			aw_addr_reg       <= 8'h00;
			w_data_reg        <= 32'h00000000;
			w_strb_reg        <= 4'h0;
			addr_reg          <= 13'h0000;
			wdata_reg         <= 8'h00;
			write_sel_reg     <= 1'b0;
			fetch_sel_reg     <= 1'b0;
			go_reg            <= 1'b0;
			wait_reg          <= 1'b0;
			stop_reg          <= 1'b0;
			imask_reg         <= 1'b1;
			sp_reg            <= `STACK_TOP;
		end else begin
			go_reg            <= 1'b0;
			s_axi_awready_out <= ~aw_got_reg & s_axi_awvalid_in & ~s_axi_awready_out;
			s_axi_wready_out  <= ~w_got_reg & s_axi_wvalid_in & ~s_axi_wready_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata_in;
				w_strb_reg <= s_axi_wstrb_in;
			end
			if (do_write) begin
				aw_got_reg       <= 1'b0;
				w_got_reg        <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= `AXI_RESP_OKAY;
				case (aw_addr_reg)
					`REG_CTRL: if (w_strb_reg[0] && !busy_reg) begin
						go_reg        <= w_data_reg[`CTRL_GO] | w_data_reg[`CTRL_PUSH] |
							w_data_reg[`CTRL_PULL];
						write_sel_reg <= w_data_reg[`CTRL_WRITE] | w_data_reg[`CTRL_PUSH];
						fetch_sel_reg <= w_data_reg[`CTRL_FETCH];
						wait_reg      <= w_data_reg[`CTRL_WAIT];
						stop_reg      <= w_data_reg[`CTRL_STOP];
						imask_reg     <= w_data_reg[`CTRL_IMASK];
						if (w_data_reg[`CTRL_SPRST])
							sp_reg <= `STACK_TOP;
						else if (w_data_reg[`CTRL_PUSH]) begin
							addr_reg <= sp_addr;
							sp_reg   <= sp_reg - 6'h01;
						end else if (w_data_reg[`CTRL_PULL]) begin
							addr_reg <= {`STACK_PAGE, sp_reg + 6'h01};
							sp_reg   <= sp_reg + 6'h01;
						end
					end
					`REG_ADDR:  addr_reg  <= w_data_reg[12:0];
					`REG_WDATA: wdata_reg <= w_data_reg[7:0];
					default:    s_axi_bresp_out <= `AXI_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid_out && s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
			s_axi_arready_out <= s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out;
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rresp_out  <= `AXI_RESP_OKAY;
				case (s_axi_araddr_in)
					`REG_CTRL:   s_axi_rdata_out <= {26'h0, imask_reg, stop_reg, wait_reg,
						fetch_sel_reg, write_sel_reg, 1'b0};
					`REG_ADDR:   s_axi_rdata_out <= {19'h0, addr_reg};
					`REG_WDATA:  s_axi_rdata_out <= {24'h0, wdata_reg};
					`REG_STATUS: s_axi_rdata_out <= {27'h0, vector_hit_reg, servicing_reg,
						irq_pending_out, done_reg, busy_reg | go_reg};
					`REG_RDATA:  s_axi_rdata_out <= {24'h0, rdata_reg};
					`REG_SP:     s_axi_rdata_out <= {19'h0, sp_addr};
					default: begin
						s_axi_rdata_out <= 32'h00000000;
						s_axi_rresp_out <= `AXI_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

endmodule // muxed_bus_interface

// file: rtl/muxed_bus_regs.vh
// Purpose: constants for the multiplexed bus and port interface
// Assumes: 13-bit address space, one internal 128-byte page
// Notes:
`ifndef MUXED_BUS_REGS_VH
`define MUXED_BUS_REGS_VH
`define OSC_DIV          3'h5
`define PH_ADDR          3'h0
`define STACK_PAGE       7'h01
`define PH_AS_HI         3'h1
`define PH_AS_LO         3'h2
`define PH_DS_HI         3'h3
`define PH_DS_LO         3'h4
`define ADR_PORTA_DATA   7'h00
`define ADR_PORTB_DATA   7'h01
`define ADR_PORTA_DIR    7'h04
`define ADR_PORTB_DIR    7'h05
`define ADR_EXT_LO_FIRST 7'h06
`define ADR_EXT_LO_LAST  7'h0F
`define INTERNAL_TOP     13'h007F
`define RAM_BASE         7'h10
`define VECTOR_BASE      13'h1FF6
`define STACK_TOP        6'h3F
`define AXI_RESP_OKAY    2'h0
`define AXI_RESP_SLVERR  2'h2
`define REG_CTRL         8'h00
`define REG_ADDR         8'h04
`define REG_WDATA        8'h08
`define REG_STATUS       8'h0C
`define REG_RDATA        8'h10
`define REG_SP           8'h14
`define CTRL_GO          0
`define CTRL_WRITE       1
`define CTRL_FETCH       2
`define CTRL_WAIT        3
`define CTRL_STOP        4
`define CTRL_IMASK       5
`define CTRL_PUSH        6
`define CTRL_PULL        7
`define CTRL_SPRST       8
`define CTRL_IACK        9
`endif

// file: tb/ext_memory_model.sv
// Purpose: external memory with address latch on the multiplexed bus
// Assumes: strobes registered on sys_clk_in, one clock high each
// Notes: true read data only while the data strobe is high, inverted data otherwise
module ext_memory_model (
	input  logic       sys_clk_in,
	input  logic       address_strobe_in,
	input  logic       data_strobe_in,
	input  logic       read_write_n_in,
	input  logic [4:0] upper_in,
	input  logic [7:0] bus_out_in,
	input  logic       bus_oe_in,
	output logic [7:0] bus_in_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:8191];
	logic [12:0] adr_reg;
	initial begin
		adr_reg = 13'h0000;
		for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ {3'h0, i[12:8]} ^ 8'h5A;
	end
	// low byte latched as strobe falls
	always @(posedge sys_clk_in) begin
		if (address_strobe_in) adr_reg <= {upper_in, bus_out_in};
		if (data_strobe_in && !read_write_n_in && bus_oe_in) mem[adr_reg] <= bus_out_in;
	end
	// Inverted data outside the strobe so stale values never pass
	assign bus_in_out = data_strobe_in ? mem[adr_reg] : ~mem[adr_reg];
endmodule // ext_memory_model

// file: tb/muxed_bus_and_port_interface_tb.sv
// Purpose: self-checking bench for the multiplexed bus interface
// Assumes: 10 MHz clock, AXI4-Lite command port
// Notes: random port values from a fixed seed
`include "muxed_bus_regs.vh"
module muxed_bus_and_port_interface_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, irq_n = 1;
	logic [7:0]  awa = 8'h00, ara = 8'h00, pa = 8'h00, pb = 8'h00, bin, bout, pao, pbo, pae, pbe;
	logic [31:0] wd = 32'h0, rd, rv;
	logic        awr, wr, bvl, arr, rvl, as, ds, rwn, boe, lif, ipend;
	logic [1:0]  brsp, rrsp, rsp;
	logic [4:0]  up;
	integer      seed = 32'hd721, fail_count = 0, compares = 0, n, fetches;
	always #50 clk = ~clk;
	muxed_bus_interface u_muxed_bus_interface (.sys_clk_in(clk), .reset_n_in(rst_n),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
		.s_axi_bresp_out(brsp), .s_axi_bvalid_out(bvl), .s_axi_bready_in(br),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rd), .s_axi_rresp_out(rrsp), .s_axi_rvalid_out(rvl), .s_axi_rready_in(rr),
		.irq_n_in(irq_n), .address_strobe_out(as), .data_strobe_out(ds), .read_write_n_out(rwn),
		.upper_address_lines_out(up), .muxed_addr_data_lines_in(bin),
		.muxed_addr_data_lines_out(bout), .muxed_addr_data_lines_oe_out(boe),
		.opcode_fetch_flag_out(lif), .port_a_pins_in(pa), .port_a_pins_out(pao),
		.port_a_pins_oe_out(pae), .port_b_pins_in(pb), .port_b_pins_out(pbo),
		.port_b_pins_oe_out(pbe), .irq_pending_out(ipend));
	ext_memory_model u_ext_memory_model (.sys_clk_in(clk), .address_strobe_in(as),
		.data_strobe_in(ds), .read_write_n_in(rwn), .upper_in(up), .bus_out_in(bout),
		.bus_oe_in(boe), .bus_in_out(bin));
	task stop_test;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick_guard;
		n++;
		if (n > 300) begin
			fail_count++;
			stop_test;
		end
	endtask
	// Handshake seen at negedge; registered outputs hold to the next edge
	task axi_wr(input [7:0] a, input [31:0] d);
		logic ah, wh, ad, wdn;
		ad = 0; wdn = 0; n = 0;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
		while (!(ad && wdn)) begin
			@(negedge clk); ah = awv && awr; wh = wv && wr; tick_guard;
			@(posedge clk); if (ah) begin awv <= 0; ad = 1; end
			if (wh) begin wv <= 0; wdn = 1; end
		end
		@(negedge clk);
		while (!bvl) begin @(negedge clk); tick_guard; end
		rsp = brsp;
		@(posedge clk); br <= 0;
	endtask
	task axi_rd(input [7:0] a);
		n = 0;
		@(posedge clk); ara <= a; arv <= 1; rr <= 1;
		@(negedge clk);
		while (!arr) begin @(negedge clk); tick_guard; end
		@(posedge clk); arv <= 0;
		@(negedge clk);
		while (!rvl) begin @(negedge clk); tick_guard; end
		rv = rd; rsp = rrsp;
		@(posedge clk); rr <= 0;
	endtask
	// Command through the bus sequencer, mask kept set
	task cmd(input [12:0] a, input [7:0] d, input [9:0] c);
		axi_wr(`REG_ADDR, {19'h0, a}); axi_wr(`REG_WDATA, {24'h0, d});
		axi_wr(`REG_CTRL, {22'h0, c} | 32'h20);
		for (int k = 0; k < 40; k++) begin
			axi_rd(`REG_STATUS);
			if (rv[1:0] === 2'b10) break;
			if (k == 39) begin fail_count++; stop_test; end
		end
	endtask
	task rd_mem(input [12:0] a);
		cmd(a, 8'h00, 10'h001); axi_rd(`REG_RDATA);
	endtask
	function automatic [7:0] ext_val(input [12:0] a);
		return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5A;
	endfunction
	function automatic [7:0] port_val(input [7:0] lat, input [7:0] dir, input [7:0] pin);
		return (lat & dir) | (pin & ~dir);
	endfunction
	logic [7:0] lat, dir;
	logic [12:0] ea;
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		rd_mem(13'h0004); chk(rv[7:0], 8'h00);
		axi_rd(`REG_SP); chk(rv[7:0], 8'h7F);
		axi_rd(8'h40); chk(rsp, `AXI_RESP_SLVERR);
		axi_wr(8'h44, 32'h0); chk(rsp, `AXI_RESP_SLVERR);
		axi_wr(`REG_ADDR, 32'h0); chk(rsp, `AXI_RESP_OKAY);
		$display("reset state done");
		for (int i = 0; i < 8; i++) begin
			lat = $random(seed); dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $random(seed);
			@(posedge clk); pa <= $random(seed); pb <= $random(seed);
			cmd({12'h000, i[0]}, lat, 10'h003); cmd({12'h002, i[0]}, dir, 10'h003);
			chk(i[0] ? pbe : pae, dir);
			chk((i[0] ? pbo : pao) & dir, lat & dir);
			rd_mem({12'h002, i[0]}); chk(rv[7:0], dir);
			rd_mem({12'h000, i[0]}); chk(rv[7:0], port_val(lat, dir, i[0] ? pb : pa));
		end
		// Mid-run reset: directions clear, port B latch survives
		@(posedge clk); rst_n <= 0;
		repeat (2) @(posedge clk); rst_n <= 1;
		@(negedge clk); chk(pbo, lat);
		chk(pbe, 8'h00);
		$display("port test done");
		for (int i = 0; i < 6; i++) begin
			ea = (i == 0) ? 13'h0006 : (i == 1) ? 13'h1FF8 : 13'h0080 + $random(seed) % 13'h1F00;
			rd_mem(ea); chk(rv[7:0], ext_val(ea));
			axi_rd(`REG_STATUS); chk(rv[4], i == 1);
		end
		cmd(13'h0030, 8'hC3, 10'h003); chk(u_ext_memory_model.mem[13'h0030], 8'hC3);
		// Outside copy made to differ so a read that takes bus data shows up
		u_ext_memory_model.mem[13'h0030] = 8'h3C;
		rd_mem(13'h0030); chk(rv[7:0], 8'hC3);
		$display("memory test done");
		cmd(13'h0000, 8'h00, 10'h040); axi_rd(`REG_SP); chk(rv[7:0], 8'h7E);
		cmd(13'h0000, 8'h00, 10'h080); axi_rd(`REG_SP); chk(rv[7:0], 8'h7F);
		@(posedge clk); irq_n <= 0;
		@(posedge clk); irq_n <= 1;
		repeat (2) @(negedge clk); chk(ipend, 1'b0);
		axi_wr(`REG_CTRL, 32'h0); repeat (2) @(negedge clk); chk(ipend, 1'b1);
		axi_rd(`REG_STATUS); chk(rv[2], 1'b1);
		axi_wr(`REG_CTRL, 32'h228);
		axi_rd(`REG_STATUS); chk(rv[3], 1'b1);
		$display("interrupt test done");
		repeat (10) @(posedge clk);
		n = 0;
		repeat (20) begin @(negedge clk); n = n + (as | ds | !rwn); end
		chk(n, 0);
		axi_wr(`REG_CTRL, 32'h20); repeat (6) @(posedge clk);
		n = 0;
		fetches = 0;
		repeat (50) begin @(negedge clk); n = n + as; fetches = fetches + lif; end
		chk(n, 10);
		chk(fetches, 0);
		// A fetch command ends the service window
		cmd(13'h0100, 8'h00, 10'h005); axi_rd(`REG_STATUS); chk(rv[3], 1'b0);
		n = 0;
		repeat (50) begin @(negedge clk); n = n + lif; end
		chk(n, 10);
		$display("strobe test done");
		stop_test;
	end
endmodule // muxed_bus_and_port_interface_tb
bind muxed_bus_interface muxed_bus_chk u_muxed_bus_chk (.sys_clk_in(sys_clk_in),
	.reset_n_in(reset_n_in), .address_strobe_out(address_strobe_out),
	.data_strobe_out(data_strobe_out), .read_write_n_out(read_write_n_out),
	.upper_address_lines_out(upper_address_lines_out),
	.muxed_addr_data_lines_oe_out(muxed_addr_data_lines_oe_out),
	.opcode_fetch_flag_out(opcode_fetch_flag_out), .port_a_pins_oe_out(port_a_pins_oe_out),
	.port_b_pins_oe_out(port_b_pins_oe_out));

// file: tb/muxed_bus_chk.sv
// Purpose: port-level checks of bus strobes, direction and ports
// Assumes: bus cycle of five clocks, strobes one clock wide
// Notes: bound to the top module from the bench
module muxed_bus_chk (
	input logic       sys_clk_in,
	input logic       reset_n_in,
	input logic       address_strobe_out,
	input logic       data_strobe_out,
	input logic       read_write_n_out,
	input logic [4:0] upper_address_lines_out,
	input logic       muxed_addr_data_lines_oe_out,
	input logic       opcode_fetch_flag_out,
	input logic [7:0] port_a_pins_oe_out,
	input logic [7:0] port_b_pins_oe_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	property p_as_period; address_strobe_out |=> !address_strobe_out [*4]; endproperty
	a_as_period: assert property (p_as_period) else $error("address strobe spacing");
	property p_ds_period; data_strobe_out |=> !data_strobe_out [*4]; endproperty
	a_ds_period: assert property (p_ds_period) else $error("data strobe spacing");
	property p_upper; address_strobe_out |=> $stable(upper_address_lines_out) [*3]; endproperty
	a_upper: assert property (p_upper) else $error("upper address moved");
	property p_rw_rest; data_strobe_out |=> read_write_n_out; endproperty
	a_rw_rest: assert property (p_rw_rest) else $error("direction not back at read");
	property p_oe_wr; data_strobe_out && muxed_addr_data_lines_oe_out |-> !read_write_n_out;
	endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("bus driven on read");
	property p_as_oe; address_strobe_out |-> muxed_addr_data_lines_oe_out; endproperty
	a_as_oe: assert property (p_as_oe) else $error("address not driven");
	property p_oe_off; data_strobe_out |=> !muxed_addr_data_lines_oe_out; endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus held after strobe");
	property p_fetch; opcode_fetch_flag_out |-> data_strobe_out; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch flag outside strobe");
	// Looks one edge on so the enables show the direction registers, not their reset
	property p_rst_dir; $rose(reset_n_in) |=> (port_a_pins_oe_out | port_b_pins_oe_out) == 8'h00;
	endproperty
	a_rst_dir: assert property (p_rst_dir) else $error("direction not cleared");
endmodule // muxed_bus_chk
